//--- ebo_axil_slave.sv
`timescale 1ns/1ns

module ebo_axil_slave
	import ebo_pkg::*;
(
	// Clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// AXI4-Lite write channels
	input  wire logic [`EBO_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [`EBO_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Register file side
	output ebo_wr_t                     wr,
	output logic                        wr_en,
	input  wire logic                   wr_hit,
	output logic [`EBO_ADDR_W-1:0]      rd_addr,
	input  wire logic [31:0]            rd_data,
	input  wire logic                   rd_hit
);

	logic                   awready_q, awready_d, wready_q, wready_d;
	logic                   bvalid_q, bvalid_d, wr_en_q, wr_en_d;
	logic [1:0]             bresp_q, bresp_d, rresp_q, rresp_d;
	logic                   arready_q, arready_d, rvalid_q, rvalid_d;
	logic                   rd_pend_q, rd_pend_d;
	logic [31:0]            rdata_q, rdata_d;
	logic [`EBO_ADDR_W-1:0] rd_addr_q, rd_addr_d;
	ebo_wr_t                wr_q, wr_d;

	// Address and data are taken in either order; the write fires once both are held
	always_comb begin
		awready_d = awready_q;
		wready_d  = wready_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		wr_d      = wr_q;
		wr_en_d   = 1'b0;
		arready_d = arready_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		rd_addr_d = rd_addr_q;
		rd_pend_d = 1'b0;
		if (s_axi_awvalid && awready_q) begin
			wr_d.addr = s_axi_awaddr;
			awready_d = 1'b0;
		end
		if (s_axi_wvalid && wready_q) begin
			wr_d.data = s_axi_wdata;
			wr_d.strb = s_axi_wstrb;
			wready_d  = 1'b0;
		end
		if (!awready_q && !wready_q && !bvalid_q) begin
			wr_en_d  = 1'b1;
			bvalid_d = 1'b1;
			bresp_d  = wr_hit ? `EBO_RESP_OKAY : `EBO_RESP_SLVERR;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d  = 1'b0;
			awready_d = 1'b1;
			wready_d  = 1'b1;
		end
		// Read data is sampled one cycle after the address so the decode stays registered
		if (s_axi_arvalid && arready_q) begin
			rd_addr_d = s_axi_araddr;
			arready_d = 1'b0;
			rd_pend_d = 1'b1;
		end
		if (rd_pend_q) begin
			rvalid_d = 1'b1;
			rdata_d  = rd_data;
			rresp_d  = rd_hit ? `EBO_RESP_OKAY : `EBO_RESP_SLVERR;
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
	end

	// Channel state registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= `EBO_RESP_OKAY;
			wr_q      <= '0;
			wr_en_q   <= 1'b0;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= `EBO_RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
			rd_addr_q <= '0;
			rd_pend_q <= 1'b0;
		end else begin
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			wr_q      <= wr_d;
			wr_en_q   <= wr_en_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
			rd_addr_q <= rd_addr_d;
			rd_pend_q <= rd_pend_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign wr            = wr_q;
	assign wr_en         = wr_en_q;
	assign rd_addr       = rd_addr_q;

endmodule : ebo_axil_slave

//--- ebo_ctrl.sv
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns

module ebo_ctrl
	import ebo_pkg::*;
#(
	parameter int CNT_W    = 16,
	parameter int N_EXT    = 4
)(
	// Clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// AXI4-Lite register port
	input  wire logic [`EBO_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`EBO_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Bus arbitration
	input  wire logic                   bus_master,
	input  wire logic                   hold_req,
	output logic                        hold_out,
	// Extended user pins
	output logic [N_EXT-1:0]            ext_user_pins_o,
	output logic [N_EXT-1:0]            ext_user_pins_oe_n,
	// Receive filter and repeater management bus
	input  ebo_rx_t                     rx,
	output logic                        packet_compress_out,
	output logic                        packet_compress_oe_n,
	output logic                        rx_accept,
	output logic                        rx_reject
);

	////////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	// The level field is four bits wide in the register; counters share one word
	if (N_EXT != 4) begin : g_bad_ext
		$error("ebo_ctrl: N_EXT must be 4");
	end
	if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
		$error("ebo_ctrl: CNT_W must be 1 to 16");
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus slave

	ebo_wr_t                wr;
	logic                   wr_en;
	logic                   wr_hit;
	logic [`EBO_ADDR_W-1:0] rd_addr;
	logic [31:0]            rd_data;
	logic                   rd_hit;

	ebo_axil_slave u_slave (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr            (wr),
		.wr_en         (wr_en),
		.wr_hit        (wr_hit),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_hit        (rd_hit)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register file

	ebo_ctl_t           ctl_q, ctl_d;
	logic [N_EXT-1:0]   lvl_q, lvl_d;
	logic               lvl_written_q, lvl_written_d;
	logic               ext_mode_q, ext_mode_d;
	logic               acc_bcast_q, acc_bcast_d;
	logic               acc_phys_q, acc_phys_d;
	logic               acc_mcast_q, acc_mcast_d;
	logic               wr_ext, wr_aux;
	logic               cmp_active;
	logic               last_accept_q, last_reject_q;
	logic [CNT_W-1:0]   cmp_cnt_q, rej_cnt_q;

	// Writes only land in registers the software may change; counters and status are read-only
	always_comb begin
		wr_ext = 1'b0;
		wr_aux = 1'b0;
		wr_hit = 1'b1;
		if (wr.addr == `EBO_OFF_EXT_OPT) begin
			wr_ext = wr_en;
		end else if (wr.addr == `EBO_OFF_AUX_CFG) begin
			wr_aux = wr_en;
		end else if (wr.addr == `EBO_OFF_STATUS || wr.addr == `EBO_OFF_COUNTS) begin
			wr_hit = 1'b1;
		end else begin
			wr_hit = 1'b0;
		end
	end

	// Next values of the control fields; reserved positions are dropped, not stored
	always_comb begin
		ctl_d         = ctl_q;
		lvl_d         = lvl_q;
		lvl_written_d = lvl_written_q;
		ext_mode_d    = ext_mode_q;
		acc_bcast_d   = acc_bcast_q;
		acc_phys_d    = acc_phys_q;
		acc_mcast_d   = acc_mcast_q;
		if (wr_ext && wr.strb[0]) begin
			ctl_d.hold_edge = wr.data[`EBO_HOLD_EDGE_BIT];
			ctl_d.cmp_match = wr.data[`EBO_CMP_MATCH_BIT];
			ctl_d.cmp_miss  = wr.data[`EBO_CMP_MISS_BIT];
			ctl_d.reject    = wr.data[`EBO_REJECT_BIT];
		end
		if (wr_ext && wr.strb[1]) begin
			lvl_d         = wr.data[`EBO_LVL_MSB:`EBO_LVL_LSB];
			lvl_written_d = 1'b1;
		end
		if (wr_aux && wr.strb[0]) begin
			acc_bcast_d = wr.data[`EBO_ACC_BCAST_BIT];
			acc_phys_d  = wr.data[`EBO_ACC_PHYS_BIT];
			acc_mcast_d = wr.data[`EBO_ACC_MCAST_BIT];
		end
		if (wr_aux && wr.strb[1]) begin
			ext_mode_d = wr.data[`EBO_EXT_MODE_BIT];
		end
	end

	// Control fields clear on hardware reset; there is no software reset input here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{ctl_q.hold_edge, ctl_q.cmp_match, ctl_q.cmp_miss, ctl_q.reject} <= `EBO_CTL_RST;
			lvl_written_q <= 1'b0;
			{ext_mode_q, acc_bcast_q, acc_phys_q, acc_mcast_q} <= `EBO_AUX_RST;
		end else begin
			ctl_q         <= ctl_d;
			lvl_written_q <= lvl_written_d;
			ext_mode_q    <= ext_mode_d;
			acc_bcast_q   <= acc_bcast_d;
			acc_phys_q    <= acc_phys_d;
			acc_mcast_q   <= acc_mcast_d;
		end
	end

	// Level bits keep no reset value; they read unknown until first written
	always_ff @(posedge aclk) begin
		lvl_q <= lvl_d;
	end

	// Read decode; unused bits read as zero
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit  = 1'b1;
		if (rd_addr == `EBO_OFF_EXT_OPT) begin
			rd_data[`EBO_LVL_MSB:`EBO_LVL_LSB] = lvl_q;
			rd_data[`EBO_HOLD_EDGE_BIT]        = ctl_q.hold_edge;
			rd_data[`EBO_CMP_MATCH_BIT]        = ctl_q.cmp_match;
			rd_data[`EBO_CMP_MISS_BIT]         = ctl_q.cmp_miss;
			rd_data[`EBO_REJECT_BIT]           = ctl_q.reject;
		end else if (rd_addr == `EBO_OFF_AUX_CFG) begin
			rd_data[`EBO_EXT_MODE_BIT]  = ext_mode_q;
			rd_data[`EBO_ACC_BCAST_BIT] = acc_bcast_q;
			rd_data[`EBO_ACC_PHYS_BIT]  = acc_phys_q;
			rd_data[`EBO_ACC_MCAST_BIT] = acc_mcast_q;
		end else if (rd_addr == `EBO_OFF_STATUS) begin
			rd_data[5:0] = {lvl_written_q, !packet_compress_oe_n, cmp_active,
				last_reject_q, last_accept_q, bus_master};
		end else if (rd_addr == `EBO_OFF_COUNTS) begin
			rd_data[31:16] = 16'(rej_cnt_q);
			rd_data[15:0]  = 16'(cmp_cnt_q);
		end else begin
			rd_hit = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Extended user pins

	logic [N_EXT-1:0] ext_o_q, ext_o_d, ext_oe_n_q, ext_oe_n_d;

	// Each pin drives its level only while master in extended mode; unwritten levels drive low
	for (genvar i = 0; i < N_EXT; i++) begin : g_ext
		always_comb begin
			ext_oe_n_d[i] = !(bus_master && ext_mode_q);
			ext_o_d[i]    = bus_master && ext_mode_q && lvl_written_q && lvl_q[i];
		end
	end

	// Pin registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_o_q    <= '0;
			ext_oe_n_q <= '1;
		end else begin
			ext_o_q    <= ext_o_d;
			ext_oe_n_q <= ext_oe_n_d;
		end
	end

	assign ext_user_pins_o    = ext_o_q;
	assign ext_user_pins_oe_n = ext_oe_n_q;

	////////////////////////////////////////////////////////////////////////////
	// Hold request launch edge

	logic hold_fall_q, hold_fall_d, hold_rise_q, hold_rise_d;

	// The falling-edge copy leads; the rising-edge copy trails it by half a clock
	always_comb begin
		hold_fall_d = hold_req;
		hold_rise_d = hold_fall_q;
	end

	// Falling-edge launch stage
	always_ff @(negedge aclk) begin
		if (!aresetn) begin
			hold_fall_q <= 1'b0;
		end else begin
			hold_fall_q <= hold_fall_d;
		end
	end

	// Rising-edge launch stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_rise_q <= 1'b0;
		end else begin
			hold_rise_q <= hold_rise_d;
		end
	end

	// Two flops, one per edge; the select only picks which one reaches the pin
	assign hold_out = ctl_q.hold_edge ? hold_rise_q : hold_fall_q;

	////////////////////////////////////////////////////////////////////////////
	// Receive filter decision and packet compress

	ebo_cmp_state_t state_q, state_d;
	logic           cmp_o_q, cmp_o_d, cmp_oe_n_q, cmp_oe_n_d;
	logic           acc_q, acc_d, rej_q, rej_d;
	logic           last_accept_d, last_reject_d;
	logic [CNT_W-1:0] cmp_cnt_d, rej_cnt_d;
	logic           class_ok, filter_ok, cmp_want, mode_ok;

	// Class accepts stay as they are; only the filter outcome is inverted
	always_comb begin
		class_ok  = (rx.broadcast && acc_bcast_q)
			|| (rx.multicast && !rx.broadcast && acc_mcast_q)
			|| (!rx.multicast && !rx.broadcast && acc_phys_q);
		filter_ok = ctl_q.reject ? !rx.filter_hit : rx.filter_hit;
		// The illegal both-set case never raises compress, but unlike neither mode it keeps the pin driven
		mode_ok   = ctl_q.cmp_match ^ ctl_q.cmp_miss;
		cmp_want  = !rx.broadcast && mode_ok
			&& ((ctl_q.cmp_match && rx.filter_hit)
			|| (ctl_q.cmp_miss && !rx.filter_hit));
	end

	// Compress sequencer and accept/reject pulses
	always_comb begin
		state_d       = state_q;
		acc_d         = 1'b0;
		rej_d         = 1'b0;
		last_accept_d = last_accept_q;
		last_reject_d = last_reject_q;
		cmp_cnt_d     = cmp_cnt_q;
		rej_cnt_d     = rej_cnt_q;
		if (rx.addr_done) begin
			acc_d         = class_ok || filter_ok;
			rej_d         = !(class_ok || filter_ok);
			last_accept_d = acc_d;
			last_reject_d = rej_d;
			if (rej_d) begin
				rej_cnt_d = rej_cnt_q + 1'b1;
			end
		end
		case (state_q)
			EBO_CMP_IDLE: begin
				// A packet that ends in the same cycle never raises compress
				if (rx.addr_done && cmp_want && !rx.pkt_end) begin
					state_d   = EBO_CMP_ACTIVE;
					cmp_cnt_d = cmp_cnt_q + 1'b1;
				end
			end
			EBO_CMP_ACTIVE: begin
				if (rx.pkt_end) begin
					state_d = EBO_CMP_IDLE;
				end
			end
			default: begin
				state_d = EBO_CMP_IDLE;
			end
		endcase
		cmp_active = (state_d == EBO_CMP_ACTIVE);
		cmp_o_d    = cmp_active;
		// Float the pin while neither compress mode is chosen
		cmp_oe_n_d = !(ctl_q.cmp_match || ctl_q.cmp_miss);
	end

	// Receive decision registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q       <= EBO_CMP_IDLE;
			cmp_o_q       <= 1'b0;
			cmp_oe_n_q    <= 1'b1;
			acc_q         <= 1'b0;
			rej_q         <= 1'b0;
			last_accept_q <= 1'b0;
			last_reject_q <= 1'b0;
			cmp_cnt_q     <= '0;
			rej_cnt_q     <= '0;
		end else begin
			state_q       <= state_d;
			cmp_o_q       <= cmp_o_d;
			cmp_oe_n_q    <= cmp_oe_n_d;
			acc_q         <= acc_d;
			rej_q         <= rej_d;
			last_accept_q <= last_accept_d;
			last_reject_q <= last_reject_d;
			cmp_cnt_q     <= cmp_cnt_d;
			rej_cnt_q     <= rej_cnt_d;
		end
	end

	assign packet_compress_out  = cmp_o_q;
	assign packet_compress_oe_n = cmp_oe_n_q;
	assign rx_accept            = acc_q;
	assign rx_reject            = rej_q;

endmodule : ebo_ctrl

//--- ebo_ctrl_chk.sv
`timescale 1ns/1ns

module ebo_ctrl_chk
	import ebo_pkg::*;
#(
	parameter int N_EXT = 4
)(
	// Clock and reset
	input wire logic             aclk,
	input wire logic             aresetn,
	// Arbitration and pins
	input wire logic             bus_master,
	input wire logic             hold_req,
	input wire logic             hold_out,
	input wire logic [N_EXT-1:0] ext_user_pins_oe_n,
	// Receive side
	input wire ebo_rx_t          rx,
	input wire logic             packet_compress_out,
	input wire logic             packet_compress_oe_n,
	input wire logic             rx_accept,
	input wire logic             rx_reject
);

	// One clock domain, so one default clock and reset
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////
	// Pins and hold
	property p_rst_pins; $rose(aresetn) |-> &ext_user_pins_oe_n && !packet_compress_out; endproperty
	a_rst_pins: assert property (p_rst_pins) else $error("pins active after reset");
	// Either launch edge settles within two clocks
	property p_hold; $stable(hold_req) && $past(hold_req) == $past(hold_req, 2) |-> hold_out == hold_req; endproperty
	a_hold: assert property (p_hold) else $error("hold output lags request");
	property p_ext_off; !bus_master |=> &ext_user_pins_oe_n; endproperty
	a_ext_off: assert property (p_ext_off) else $error("user pins driven without bus");

	////////////////////////////////////////////////////////////////////////
	// Filter verdict and compress output
	property p_verdict; rx.addr_done |=> rx_accept ^ rx_reject; endproperty
	a_verdict: assert property (p_verdict) else $error("no single verdict");
	property p_cause; rx_accept || rx_reject |-> $past(rx.addr_done); endproperty
	a_cause: assert property (p_cause) else $error("verdict without compare");
	property p_cmp_rise; $rose(packet_compress_out) |-> $past(rx.addr_done) && !$past(rx.broadcast); endproperty
	a_cmp_rise: assert property (p_cmp_rise) else $error("bad compress start");
	property p_cmp_oe; packet_compress_out |-> !packet_compress_oe_n; endproperty
	a_cmp_oe: assert property (p_cmp_oe) else $error("compress high but floating");
	property p_cmp_hold; packet_compress_out && !rx.pkt_end |=> packet_compress_out; endproperty
	a_cmp_hold: assert property (p_cmp_hold) else $error("compress dropped early");
	property p_cmp_end; rx.pkt_end |=> !packet_compress_out; endproperty
	a_cmp_end: assert property (p_cmp_end) else $error("compress past packet end");

endmodule : ebo_ctrl_chk

bind ebo_ctrl ebo_ctrl_chk #(.N_EXT(N_EXT)) u_ebo_ctrl_chk (
	.aclk(aclk), .aresetn(aresetn), .bus_master(bus_master), .hold_req(hold_req),
	.hold_out(hold_out), .ext_user_pins_oe_n(ext_user_pins_oe_n), .rx(rx),
	.packet_compress_out(packet_compress_out), .packet_compress_oe_n(packet_compress_oe_n),
	.rx_accept(rx_accept), .rx_reject(rx_reject)
);

//--- ebo_far_model.sv
`timescale 1ns/1ns

module ebo_far_model
	import ebo_pkg::*;
(
	// Clock in, filter result out
	input wire logic aclk,
	output ebo_rx_t  rx
);

	initial rx = '0;

	// Compare result valid for one cycle only; levels scramble after it
	task automatic addr_phase(input logic h, input logic b, input logic m);
		@(posedge aclk);
		rx <= {1'h1, h, b, m, 1'h0};
		@(posedge aclk);
		rx <= {1'h0, !h, !b, !m, 1'h0};
	endtask : addr_phase

	// End of reception always follows the compare
	task automatic end_phase;
		@(posedge aclk);
		rx.pkt_end <= 1'h1;
		@(posedge aclk);
		rx.pkt_end <= 1'h0;
	endtask : end_phase

endmodule : ebo_far_model

//--- ebo_pkg.sv
package ebo_pkg;

`include "ebo_regs.svh"

	// Packet compress sequencer, Gray coded
	typedef enum logic [1:0] {
		EBO_CMP_IDLE   = 2'h0,
		EBO_CMP_ACTIVE = 2'h1
	} ebo_cmp_state_t;

	// One register write as handed from the bus slave to the register file
	typedef struct packed {
		logic [`EBO_ADDR_W-1:0] addr;
		logic [31:0]            data;
		logic [3:0]             strb;
	} ebo_wr_t;

	// Receive-side filter outcome for the packet under way
	typedef struct packed {
		logic addr_done;
		logic filter_hit;
		logic broadcast;
		logic multicast;
		logic pkt_end;
	} ebo_rx_t;

	// Control fields of the extended bus option register
	typedef struct packed {
		logic hold_edge;
		logic cmp_match;
		logic cmp_miss;
		logic reject;
	} ebo_ctl_t;

endpackage : ebo_pkg

//--- ebo_regs.svh
`ifndef EBO_REGS_SVH
`define EBO_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the AXI4-Lite bus
`define EBO_ADDR_W          12
`define EBO_OFF_EXT_OPT     12'h000
`define EBO_OFF_AUX_CFG     12'h004
`define EBO_OFF_STATUS      12'h008
`define EBO_OFF_COUNTS      12'h00C

////////////////////////////////////////////////////////////////////////////////
// Field positions of the extended bus option register
`define EBO_LVL_MSB         15
`define EBO_LVL_LSB         12
`define EBO_HOLD_EDGE_BIT   4
`define EBO_CMP_MATCH_BIT   2
`define EBO_CMP_MISS_BIT    1
`define EBO_REJECT_BIT      0

// Field positions of the auxiliary configuration register
`define EBO_EXT_MODE_BIT    15
`define EBO_ACC_BCAST_BIT   2
`define EBO_ACC_PHYS_BIT    1
`define EBO_ACC_MCAST_BIT   0

////////////////////////////////////////////////////////////////////////////////
// Reset values and bus answers
`define EBO_CTL_RST         4'h0
`define EBO_AUX_RST         4'h0
`define EBO_RESP_OKAY       2'h0
`define EBO_RESP_SLVERR     2'h2

`endif

//--- tb.sv
`timescale 1ns/1ns

module tb
	import ebo_pkg::*;
;
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic [11:0] aw = '0, ar = '0;
	logic [31:0] wd = '0, rd;
	logic        awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
	logic        bm = 1'h0, hreq = 1'h0;
	logic        awr, wrdy, bv, arr, rv, hout, pco, pcoe, acc, rej;
	logic [1:0]  bresp, rresp;
	logic [3:0]  pins, pins_oe;
	ebo_rx_t     rx;
	int          fail_count = 0, num_checks = 0;
	int unsigned lvl, cm, cn, pe, r, e_acc, e_cmp, ctl, n_rej = 0, n_cmp = 0;
	logic        rj = 1'h0, ab = 1'h0, ap = 1'h0, accept_all_multicast = 1'h0, h, b, mc;

	ebo_ctrl u_ebo_ctrl (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .bus_master(bm), .hold_req(hreq), .hold_out(hout),
		.ext_user_pins_o(pins), .ext_user_pins_oe_n(pins_oe), .rx(rx),
		.packet_compress_out(pco), .packet_compress_oe_n(pcoe), .rx_accept(acc),
		.rx_reject(rej));
	ebo_far_model u_ebo_far_model (.aclk(aclk), .rx(rx));

	// 50 MHz clock
	initial forever #10 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	// Address and data offered together; each dropped once taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		aw <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		for (n = 0; n < 100 && !bv; n++) begin
			@(posedge aclk);
			if (awr) awv <= 1'h0;
			if (wrdy) wv <= 1'h0;
		end
		br <= 1'h0;
		chk(bresp, er);
		chk(n < 100, 1);
	endtask : axi_wr

	task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] k,
		input logic [1:0] er);
		int n;
		@(posedge aclk);
		ar <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		for (n = 0; n < 100 && !rv; n++) begin
			@(posedge aclk);
			if (arr) arv <= 1'h0;
		end
		rr <= 1'h0;
		chk(rd & k, e);
		chk(rresp, er);
		chk(n < 100, 1);
	endtask : axi_rd

	// Reserved positions always written as zero
	// Only called with no packet under way, the nearest thing to a held soft reset
	task automatic cfg;
		ctl = (lvl << 12) | (pe << 4) | (cm << 2) | (cn << 1) | rj;
		axi_wr(12'h000, ctl, 2'h0);
		axi_wr(12'h004, 32'h8000 | (ab << 2) | (ap << 1) | accept_all_multicast, 2'h0);
		axi_rd(12'h000, ctl, 32'hFFFF, 2'h0);
	endtask : cfg

	////////////////////////////////////////////////////////////////////////
	// Hang guard, far above the expected run
	initial begin
		#1_000_000;
		fail_count++;
		tally_and_finish;
	end

	initial begin
		void'($urandom(42737));
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		#1;
		chk(pins_oe, 4'hF);
		chk(pcoe, 1);
		axi_rd(12'h000, 0, 32'h0FFF, 2'h0);
		axi_rd(12'h010, 0, 32'hFFFFFFFF, 2'h2);
		axi_wr(12'h010, 32'h1, 2'h2);
		// User pins follow levels only as master in extended mode
		lvl = $urandom % 16;
		cfg;
		bm <= 1'h1;
		repeat (2) @(posedge aclk);
		#1;
		chk(pins, lvl);
		chk(pins_oe, 0);
		axi_wr(12'h004, 32'h0, 2'h0);
		repeat (2) @(posedge aclk);
		#1;
		chk(pins_oe, 4'hF);
		// Launch edge of the hold request
		for (pe = 0; pe < 2; pe++) begin
			cfg;
			for (int v = 1; v >= 0; v--) begin
				@(posedge aclk);
				hreq <= v[0];
				@(negedge aclk);
				#1;
				chk(hout, pe ? !v : v);
				@(posedge aclk);
				#1;
				chk(hout, v);
			end
		end
		// Random packets against the filter model; never both compress bits
		pe = 0;
		repeat (30) begin
			r = $urandom;
			cm = r % 3 == 1;
			cn = r % 3 == 2;
			{rj, ab, ap, accept_all_multicast, h, b, mc} = {r[4], r[5], r[6], r[7], r[8], r[9], r[10]};
			lvl = r[15:12];
			cfg;
			#1;
			chk(pcoe, !(cm | cn));
			e_acc = (b ? ab : (mc ? accept_all_multicast : ap)) | (rj ? !h : h);
			e_cmp = !b && (cm ? h : (cn ? !h : 0));
			u_ebo_far_model.addr_phase(h, b, mc);
			#1;
			chk(acc, e_acc);
			chk(rej, !e_acc);
			chk(pco, e_cmp);
			repeat (r[18:17]) @(posedge aclk);
			#1;
			chk(pco, e_cmp);
			u_ebo_far_model.end_phase;
			#1;
			chk(pco, 0);
			n_rej += !e_acc;
			n_cmp += e_cmp;
		end
		// Reject and compress tallies kept by the model
		axi_rd(12'h00C, (n_rej << 16) | n_cmp, 32'hFFFFFFFF, 2'h0);
		// Second reset in mid-run clears the controls
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		axi_rd(12'h000, 0, 32'h0FFF, 2'h0);
		axi_rd(12'h004, 0, 32'hFFFF, 2'h0);
		tally_and_finish;
	end

endmodule : tb
